// [aal_exec.sv]
// execute stage for add-immediate and register-and
// assumes the processor supplies the word and both operands in one cycle
// assumes rst is synchronous, active high, and ref_clk the only clock
// results leave one clock after issue; there is no stall input
`timescale 1ns/1ns
module aal_exec #(
    parameter int DataWidth = 32
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // issued instruction
    input wire logic issueValid,
    input wire logic [31:0] instrWord,
    input wire logic [DataWidth-1:0] firstSourceRegVal,
    input wire logic [DataWidth-1:0] secondFieldRegVal,
    // write-back
    output logic wbValid,
    output logic [4:0] wbIndex,
    output logic [DataWidth-1:0] wbData,
    // signed overflow seen by the adder, informative only
    output logic addOverflow,
    // word was neither of the two instructions
    output logic unknownInstr
);
    // ****************************************
    // local sizes
    // ****************************************
    // immediate width tracks the field bounds, so a moved field moves it too
    localparam int ImmWidth = aal_pkg::ImmHi - aal_pkg::ImmLo + 1;
    localparam int Msb = DataWidth - 1; // sign bit of a data word
    localparam int ExtWidth = DataWidth - ImmWidth; // bits filled by sign extension
    // limitation: DataWidth below the immediate width is not supported
    // ****************************************
    // decode
    // ****************************************
    // field slices are renames only; operands arrive already read, so the
    // first source index itself is not needed inside this block
    // b field: addi destination, and second source
    wire logic [4:0] secondFieldReg = instrWord[aal_pkg::FieldBHi:aal_pkg::FieldBLo];
    // c field: and destination
    wire logic [4:0] thirdFieldDestReg = instrWord[aal_pkg::FieldCHi:aal_pkg::FieldCLo];
    // raw immediate, not yet extended
    wire logic [ImmWidth-1:0] sixteenBitImmediate = instrWord[aal_pkg::ImmHi:aal_pkg::ImmLo];
    // major opcode, same place in both formats
    wire logic [5:0] opcode = instrWord[aal_pkg::OpHi:aal_pkg::OpLo];
    // extended opcode, meaningful only in r-type words
    wire logic [5:0] opx = instrWord[aal_pkg::OpxHi:aal_pkg::OpxLo];
    // must be zero for and; nonzero means some other instruction
    wire logic [4:0] shField = instrWord[aal_pkg::ShHi:aal_pkg::ShLo];
    wire logic isAddImm = issueValid && (opcode == aal_pkg::OpAddImm);
    wire logic isRType = issueValid && (opcode == aal_pkg::OpRType);
    wire logic isAnd = isRType && (opx == aal_pkg::OpxAnd) && (shField == aal_pkg::ShZero);
    // neither instruction; the core decides how to trap it
    wire logic unknownSel = issueValid && !isAddImm && !isAnd;
    // ****************************************
    // datapath
    // ****************************************
    // both results are built every cycle and picked late, so the adder
    // does not wait on decode; costs a little power in idle cycles
    // sign-extend the immediate
    wire logic [DataWidth-1:0] immExt = {{ExtWidth{sixteenBitImmediate[ImmWidth-1]}},
        sixteenBitImmediate};
    wire logic [DataWidth-1:0] sum = firstSourceRegVal + immExt;
    wire logic signsAgree = firstSourceRegVal[Msb] == immExt[Msb];
    wire logic signFlipped = sum[Msb] != firstSourceRegVal[Msb];
    wire logic ovf = signsAgree && signFlipped;
    wire logic [DataWidth-1:0] andRes = firstSourceRegVal & secondFieldRegVal;
    // ****************************************
    // write-back selection
    // ****************************************
    // unknown words carry the and result too; harmless, wbValid stays low
    wire logic [DataWidth-1:0] resSel = isAddImm ? sum : andRes;
    wire logic [4:0] dstSel = isAddImm ? secondFieldReg : thirdFieldDestReg; // and: field c
    // one write-back per decoded instruction
    wire logic wbSel = isAddImm || isAnd;
    // flag only on addi; an and never reports overflow
    wire logic ovfSel = isAddImm && ovf;
    // ****************************************
    // output registers
    // ****************************************
    // one-cycle latency, all outputs from flops; index and data load every
    // cycle so the wide path needs no enable
    // write-back strobe, one pulse per decoded word
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wbValid <= 1'b0;
        end else begin
            wbValid <= wbSel;
        end
    end
    // destination index, don't-care while wbValid is low
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wbIndex <= aal_pkg::IndexReset;
        end else begin
            wbIndex <= dstSel;
        end
    end
    // result word, don't-care while wbValid is low
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wbData <= aal_pkg::DataReset;
        end else begin
            wbData <= resSel;
        end
    end
    // informative overflow pulse, travels with wbValid
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            addOverflow <= 1'b0;
        end else begin
            addOverflow <= ovfSel;
        end
    end
    // refused word pulse, never together with wbValid
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            unknownInstr <= 1'b0;
        end else begin
            unknownInstr <= unknownSel;
        end
    end
    // ****************************************
    // checks
    // ****************************************
    // expectations are rebuilt from the raw word, not from the wires above,
    // so a broken slice or mux cannot agree with itself
    // addi sum
    a_addi_result: assert property (@(posedge ref_clk) disable iff (rst)
        isAddImm |=> wbValid && wbData == $past(firstSourceRegVal)
        + {{ExtWidth{$past(instrWord[aal_pkg::ImmHi])}},
        $past(instrWord[aal_pkg::ImmHi:aal_pkg::ImmLo])})
        else $error("add-immediate result wrong");
    a_addi_dest: assert property (@(posedge ref_clk) disable iff (rst)
        isAddImm |=> wbIndex == $past(instrWord[aal_pkg::FieldBHi:aal_pkg::FieldBLo]))
        else $error("add-immediate destination wrong");
    a_addi_notrap: assert property (@(posedge ref_clk) disable iff (rst)
        isAddImm |=> wbValid && !unknownInstr)
        else $error("add-immediate did not write back");
    a_ovf_exact: assert property (@(posedge ref_clk) disable iff (rst)
        isAddImm |=> addOverflow == (
        ($past(firstSourceRegVal[Msb]) == $past(instrWord[aal_pkg::ImmHi]))
        && (wbData[Msb] != $past(firstSourceRegVal[Msb]))))
        else $error("overflow flag wrong");
    a_ovf_flag: assert property (@(posedge ref_clk) disable iff (rst)
        addOverflow |-> wbValid && (wbData[Msb] != $past(firstSourceRegVal[Msb])))
        else $error("overflow flag inconsistent");
    a_and_result: assert property (@(posedge ref_clk) disable iff (rst)
        isAnd |=> wbValid && wbData == ($past(firstSourceRegVal) & $past(secondFieldRegVal)))
        else $error("and result wrong");
    a_and_noflag: assert property (@(posedge ref_clk) disable iff (rst)
        isAnd |=> !addOverflow && !unknownInstr)
        else $error("and raised a flag");
    a_and_dest: assert property (@(posedge ref_clk) disable iff (rst)
        isAnd |=> wbIndex == $past(instrWord[aal_pkg::FieldCHi:aal_pkg::FieldCLo]))
        else $error("and destination wrong");
    a_and_decode: assert property (@(posedge ref_clk) disable iff (rst)
        (issueValid && instrWord[aal_pkg::OpHi:aal_pkg::OpLo] == aal_pkg::OpRType
        && instrWord[aal_pkg::ShHi:aal_pkg::ShLo] != aal_pkg::ShZero)
        |=> !wbValid && unknownInstr)
        else $error("and with nonzero field accepted");
    a_opx_decode: assert property (@(posedge ref_clk) disable iff (rst)
        (issueValid && instrWord[aal_pkg::OpHi:aal_pkg::OpLo] == aal_pkg::OpRType
        && instrWord[aal_pkg::OpxHi:aal_pkg::OpxLo] != aal_pkg::OpxAnd)
        |=> !wbValid && unknownInstr)
        else $error("r-type word with other opx accepted");
    a_other_op: assert property (@(posedge ref_clk) disable iff (rst)
        (issueValid && instrWord[aal_pkg::OpHi:aal_pkg::OpLo] != aal_pkg::OpAddImm
        && instrWord[aal_pkg::OpHi:aal_pkg::OpLo] != aal_pkg::OpRType)
        |=> !wbValid && unknownInstr)
        else $error("unrelated opcode accepted");
    a_idle_nowrite: assert property (@(posedge ref_clk) disable iff (rst)
        !issueValid |=> !wbValid && !unknownInstr)
        else $error("write-back without issue");
    a_wb_after_issue: assert property (@(posedge ref_clk) disable iff (rst)
        wbValid |-> $past(issueValid))
        else $error("write-back with no issued word");
    a_unknown_after: assert property (@(posedge ref_clk) disable iff (rst)
        unknownInstr |-> $past(issueValid))
        else $error("refusal with no issued word");
    // ****************************************
    // coverage
    // ****************************************
    // main scenarios the bench must reach; the last one reaches an addi word
    // issued with an and word directly in the next cycle
    c_addi: cover property (@(posedge ref_clk) disable iff (rst) isAddImm);
    c_addi_ovf: cover property (@(posedge ref_clk) disable iff (rst) addOverflow);
    c_and: cover property (@(posedge ref_clk) disable iff (rst) isAnd);
    c_unknown: cover property (@(posedge ref_clk) disable iff (rst) unknownInstr);
    c_addi_then_and: cover property (@(posedge ref_clk) disable iff (rst) isAddImm ##1 isAnd);
endmodule

// [aal_pkg.sv]
// package for the add-immediate / register-and execute block
// assumes a 32-bit instruction word and a 32-entry register file outside
// ****************************************
// field layout and opcodes
// ****************************************
package aal_pkg;
    // source field a
    localparam int FieldAHi = 31;
    localparam int FieldALo = 27;
    // second field b
    localparam int FieldBHi = 26;
    localparam int FieldBLo = 22;
    // r-type destination field c
    localparam int FieldCHi = 21;
    localparam int FieldCLo = 17;
    // i-type immediate field
    localparam int ImmHi = 21;
    localparam int ImmLo = 6;
    // r-type extended opcode and shift field
    localparam int OpxHi = 16;
    localparam int OpxLo = 11;
    localparam int ShHi = 10;
    localparam int ShLo = 6;
    // major opcode
    localparam int OpHi = 5;
    localparam int OpLo = 0;
    // opcode values
    localparam logic [5:0] OpAddImm = 6'h04;
    localparam logic [5:0] OpRType = 6'h3A;
    localparam logic [5:0] OpxAnd = 6'h0e;
    localparam logic [4:0] ShZero = 5'h00;
    // reset values
    localparam logic [31:0] DataReset = 32'h0000_0000;
    localparam logic [4:0] IndexReset = 5'h00;
endpackage

// [tb_top.sv]
// bench for the add-immediate / register-and execute block
// assumes one result per issued word, one cycle later
`timescale 1ns/1ns
module tb_top;
    logic ref_clk = 0, rst = 1, issueValid = 0, wbValid, addOverflow, unknownInstr;
    logic [31:0] instrWord = 0, firstSourceRegVal = 0, secondFieldRegVal = 0, wbData;
    logic [31:0] rnd = 32'h0000_0009, w, a, b; // xorshift state and stimulus
    logic [4:0] wbIndex;
    logic [39:0] notes[$], nt; // {valid, unknown, ovf, index, data}
    int miscompares = 0, n_tests = 0, cyc = 0;
    aal_exec u_dut (.ref_clk(ref_clk), .rst(rst), .issueValid(issueValid),
        .instrWord(instrWord), .firstSourceRegVal(firstSourceRegVal),
        .secondFieldRegVal(secondFieldRegVal), .wbValid(wbValid), .wbIndex(wbIndex),
        .wbData(wbData), .addOverflow(addOverflow), .unknownInstr(unknownInstr));
    initial forever #25 ref_clk = ~ref_clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13; s ^= s >> 17; s ^= s << 5; return s;
    endfunction
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH result exp %h seen %h", exp, seen);
        end
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // drive one word and note what must come back
    task automatic issue(input logic [31:0] w, input logic [31:0] a, input logic [31:0] b);
        logic [31:0] s;
        @(posedge ref_clk); #5;
        issueValid = 1; instrWord = w; firstSourceRegVal = a; secondFieldRegVal = b;
        s = a + {{16{w[21]}}, w[21:6]}; // sum wraps by width
        if (w[5:0] == 6'h04) notes.push_back({2'b10, a[31] == w[21] && s[31] != a[31], w[26:22], s});
        else if (w[16:0] == {6'h0e, 5'h00, 6'h3A}) notes.push_back({3'h4, w[21:17], a & b});
        else notes.push_back({2'b01, 38'h0});
    endtask
    // watcher: each result takes the oldest note; unknown words skip data fields
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 1000) begin
            miscompares++;
            results();
        end
        if (!rst && (wbValid === 1'b1 || unknownInstr === 1'b1)) begin
            nt = notes.size() ? notes.pop_front() : 40'h0;
            chk(nt[38] ? {wbValid, unknownInstr, 38'h0} : {wbValid, unknownInstr, addOverflow, wbIndex, wbData}, nt);
        end
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        chk({wbValid, unknownInstr, addOverflow, wbIndex, wbData}, 40'h0);
        #5 rst = 0;
        // wrap at both signed limits, then a plain negative sum, no trap
        issue({5'h01, 5'h02, 16'h0001, 6'h04}, 32'h7fff_ffff, 32'h0);
        issue({5'h03, 5'h1f, 16'h8000, 6'h04}, 32'h8000_0000, 32'h0);
        issue({5'h04, 5'h05, 16'hffff, 6'h04}, 32'h0000_0000, 32'h0);
        // the first two near misses must not write back; the third is a valid and to index 5'h1f
        issue({5'h03, 5'h04, 5'h05, 6'h0e, 5'h01, 6'h3A}, 32'hffff_ffff, 32'h1234_5678);
        issue({5'h03, 5'h04, 5'h05, 6'h0f, 5'h00, 6'h3A}, 32'hffff_ffff, 32'h1234_5678);
        issue({5'h03, 5'h04, 5'h1f, 6'h0e, 5'h00, 6'h3A}, 32'hf0f0_ffff, 32'h1234_5678);
        $display("test edge cases done");
        // random mix, back to back every cycle
        for (int i = 0; i < 200; i++) begin
            rnd = xs(rnd); w = rnd; rnd = xs(rnd); a = rnd; rnd = xs(rnd); b = rnd;
            if (w[0]) w[5:0] = 6'h04;
            else if (w[1]) w[16:0] = {6'h0e, 5'h00, 6'h3A};
            issue(w, a, b);
        end
        @(posedge ref_clk); #5 issueValid = 0;
        repeat (3) @(posedge ref_clk);
        chk(40'(notes.size()), 40'h0);
        $display("test random mix done");
        results();
    end
endmodule
